// ===== hw/wdcrc_ctrl_end.sv
// controller end: forms the frame, appends checksum and fill transfers
module wdcrc_ctrl_end (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_crc_en,
   input wire logic i_write_mask_function,
   input wire logic i_bus_inversion_function,
   input wire logic i_word_valid,
   input wire logic [wdcrc_pkg::DATA_W-1:0] i_data,
   input wire logic [7:0] i_mask_lane,
   output logic o_ready,
   output logic o_alert_seen,
   wdcrc_link_if.ctrl link
);
   import wdcrc_pkg::*;

   // ******************************************************************
   // state
   // ******************************************************************
   typedef enum logic {WDCRC_TX_IDLE, WDCRC_TX_SEND} wdcrc_tx_state_t;

   wdcrc_tx_state_t state_q;
   logic [WORD_W-1:0] word_q;
   logic [CRC_W-1:0] crc_q;
   logic [3:0] idx_q;
   logic [3:0] last_q;
   logic [WORD_W-1:0] word_d;
   logic [CRC_W-1:0] crc_d;
   logic [LANES:0] first_beat;
   logic [LANES:0] next_beat;

   // frame contents for a newly offered word
   always_comb begin
      word_d = form_word(i_data, i_mask_lane,
                         i_write_mask_function | i_bus_inversion_function);
      crc_d = checksum_over_word(word_d);
      first_beat = beat_of(word_d, crc_d, 4'h0);
      next_beat = beat_of(word_q, crc_q, idx_q);
   end

   // ******************************************************************
   // sequencing
   // ******************************************************************
   // word and transfer index; outputs registered so lanes never glitch
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= WDCRC_TX_IDLE;
         word_q <= '0;
         crc_q <= CRC_INIT;
         idx_q <= 4'h0;
         last_q <= LAST_BEAT_PLAIN;
         o_ready <= 1'b1;
         link.beat_valid <= 1'b0;
         link.dq <= 8'hFF;
         link.mask_inversion_lane <= 1'b1;
      end else begin
         unique case (state_q)
            WDCRC_TX_IDLE: begin
               if (i_word_valid) begin
                  word_q <= word_d;
                  crc_q <= crc_d;
                  last_q <= i_crc_en ? LAST_BEAT_CRC : LAST_BEAT_PLAIN;
                  idx_q <= 4'h1;
                  link.beat_valid <= 1'b1;
                  link.dq <= first_beat[LANES-1:0];
                  link.mask_inversion_lane <= first_beat[LANES];
                  o_ready <= 1'b0;
                  state_q <= WDCRC_TX_SEND;
               end
            end
            WDCRC_TX_SEND: begin
               if (idx_q > last_q) begin
                  link.beat_valid <= 1'b0;
                  link.dq <= 8'hFF;
                  link.mask_inversion_lane <= 1'b1;
                  o_ready <= 1'b1;
                  state_q <= WDCRC_TX_IDLE;
               end else begin
                  link.dq <= next_beat[LANES-1:0];
                  link.mask_inversion_lane <= next_beat[LANES];
                  idx_q <= idx_q + 4'h1;
               end
            end
         endcase
      end
   end

   // alert seen as a level, mode register reads would tell its cause
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_alert_seen <= 1'b0;
      end else begin
         o_alert_seen <= ~link.alert_n;
      end
   end
endmodule : wdcrc_ctrl_end

// ===== hw/wdcrc_link_if.sv
// write data link between controller and memory, one transfer per clock
interface wdcrc_link_if;
   logic beat_valid;
   logic [7:0] dq;
   logic mask_inversion_lane;
   logic alert_o;
   logic alert_oe_n;
   logic alert_n;

   // open-drain alert with pull-up
   assign alert_n = alert_oe_n ? 1'b1 : alert_o;

   modport ctrl (
      output beat_valid,
      output dq,
      output mask_inversion_lane,
      input alert_n
   );

   modport mem (
      input beat_valid,
      input dq,
      input mask_inversion_lane,
      output alert_o,
      output alert_oe_n
   );
endinterface : wdcrc_link_if

// ===== hw/wdcrc_mem_end.sv
// memory end: gathers a frame, rebuilds the word and checks the checksum
module wdcrc_mem_end #(
   parameter int ALERT_CLKS = wdcrc_pkg::ALERT_PULSE_CLKS
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_crc_en,
   input wire logic i_write_mask_function,
   input wire logic i_bus_inversion_function,
   output logic o_word_valid,
   output logic [wdcrc_pkg::DATA_W-1:0] o_data,
   output logic [7:0] o_mask_lane,
   output logic o_crc_err,
   output logic o_frame_abort,
   wdcrc_link_if.mem link
);
   import wdcrc_pkg::*;

   // ******************************************************************
   // parameter checks
   // ******************************************************************
   if (ALERT_CLKS < 1 || ALERT_CLKS > 255) begin : g_bad_alert
      $error("alert pulse length must lie in 1..255");
   end

   // index and placement logic assume one lane bit per data transfer, eight of them
   if (WORD_W != DATA_W + LANES || DATA_BEATS != 8 || CRC_W != LANES) begin : g_bad_shape
      $error("frame shape does not fit the transfer index logic");
   end

   // checksum transfer must follow the data directly, the fill transfer right after it
   if (LAST_BEAT_CRC != CRC_BEAT + 4'h1 || LAST_BEAT_PLAIN != CRC_BEAT - 4'h1) begin : g_bad_beats
      $error("checksum and fill transfers must follow the data transfers");
   end

   localparam logic [7:0] ALERT_LOAD = 8'(ALERT_CLKS);

   // ******************************************************************
   // declarations
   // ******************************************************************
   logic [3:0] idx_q;
   logic [3:0] last_beat;
   logic [WORD_W-1:0] word_q;
   logic [WORD_W-1:0] word_now;
   logic [WORD_W-1:0] word_checked;
   logic [CRC_W-1:0] rx_crc_q;
   logic [CRC_W-1:0] calc_crc;
   logic [7:0] alert_cnt_q;
   logic frame_end;
   logic mismatch;
   logic use_upper;

   // ******************************************************************
   // frame framing
   // ******************************************************************
   // checksum mode stretches the frame by two transfers
   always_comb begin
      last_beat = i_crc_en ? LAST_BEAT_CRC : LAST_BEAT_PLAIN;
      frame_end = link.beat_valid && (idx_q == last_beat);
      use_upper = i_write_mask_function | i_bus_inversion_function;
   end

   // transfer index; a gap in the frame restarts it at zero
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         idx_q <= 4'h0;
      end else if (!link.beat_valid || frame_end) begin
         idx_q <= 4'h0;
      end else begin
         idx_q <= idx_q + 4'h1;
      end
   end

   // a frame cut short is reported, its word is dropped
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_frame_abort <= 1'b0;
      end else begin
         o_frame_abort <= !link.beat_valid && (idx_q != 4'h0);
      end
   end

   // ******************************************************************
   // word capture
   // ******************************************************************
   // data transfer t carries bit t of every lane
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         word_q <= '0;
      end else if (link.beat_valid && idx_q < CRC_BEAT) begin
         for (int n = 0; n < LANES; n++) begin
            word_q[n * DATA_BEATS + int'(idx_q)] <= link.dq[n];
         end
         word_q[DATA_W + int'(idx_q)] <= link.mask_inversion_lane;
      end
   end

   // checksum transfer; the fill transfer after it is not checked
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rx_crc_q <= CRC_INIT;
      end else if (link.beat_valid && idx_q == CRC_BEAT) begin
         rx_crc_q <= link.dq;
      end
   end

   // word including the transfer arriving now, for frames with no checksum
   always_comb begin
      word_now = word_q;
      if (link.beat_valid && idx_q < CRC_BEAT) begin
         for (int n = 0; n < LANES; n++) begin
            word_now[n * DATA_BEATS + int'(idx_q)] = link.dq[n];
         end
         word_now[DATA_W + int'(idx_q)] = link.mask_inversion_lane;
      end
   end

   // ******************************************************************
   // checksum compare
   // ******************************************************************
   // upper byte is ignored on the wire when neither function uses it
   always_comb begin
      word_checked = form_word(word_q[DATA_W-1:0], word_q[WORD_W-1:DATA_W], use_upper);
      calc_crc = checksum_over_word(word_checked);
      // any differing bit flags; full compare keeps every covered pattern
      mismatch = frame_end && i_crc_en && (calc_crc != rx_crc_q);
   end

   // delivered word; a bad word is still delivered, the alert tells
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_word_valid <= 1'b0;
         o_data <= '0;
         o_mask_lane <= UPPER_ONES;
      end else begin
         o_word_valid <= frame_end;
         if (frame_end) begin
            o_data <= word_now[DATA_W-1:0];
            o_mask_lane <= use_upper ? word_now[WORD_W-1:DATA_W] : UPPER_ONES;
         end
      end
   end

   // one-cycle error flag to the user side
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_crc_err <= 1'b0;
      end else begin
         o_crc_err <= mismatch;
      end
   end

   // ******************************************************************
   // alert pin
   // ******************************************************************
   // a new error restarts the pulse, so back-to-back errors merge
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         alert_cnt_q <= 8'h00;
      end else if (mismatch) begin
         alert_cnt_q <= ALERT_LOAD;
      end else if (alert_cnt_q != 8'h00) begin
         alert_cnt_q <= alert_cnt_q - 8'h01;
      end
   end

   // pin driven low while the pulse runs, released otherwise
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         link.alert_o <= 1'b1;
         link.alert_oe_n <= 1'b1;
      end else begin
         link.alert_o <= !(mismatch || alert_cnt_q > 8'h01);
         link.alert_oe_n <= !(mismatch || alert_cnt_q > 8'h01);
      end
   end
endmodule : wdcrc_mem_end

// ===== hw/wdcrc_pkg.sv
// Summary of operation
// - checksum polynomial is x^8 + x^2 + x + 1
// - 8-bit checksum over whole 72-bit word
// - bit 71 enters the shift first
// - checksum starts from zero every word
// - checksum bit 0 follows its xor equation
// - checksum bit 1 follows its xor equation
// - checksum bit 2 follows its xor equation
// - checksum bit 3 follows its xor equation
// - checksum bit 4 follows its xor equation
// - checksum bit 5 follows its xor equation
// - detects single, double, odd and column errors
// - checksum bit 7 follows its xor equation
// - memory compares checksums, mismatch raises alert
// - upper eight bits forced ones when unused
// - controller sends checksum, then ones, lane ones
package wdcrc_pkg;

   // ******************************************************************
   // sizes and constants
   // ******************************************************************
   localparam int WORD_W = 72;
   localparam int CRC_W = 8;
   localparam int LANES = 8;
   localparam int DATA_BEATS = 8;
   localparam int DATA_W = LANES * DATA_BEATS;
   localparam int REF_CLK_MHZ = 125;
   localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
   localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;
   localparam logic [7:0] UPPER_ONES = 8'hFF;
   localparam logic [3:0] CRC_BEAT = 4'h8;
   localparam logic [3:0] LAST_BEAT_CRC = 4'h9;
   localparam logic [3:0] LAST_BEAT_PLAIN = 4'h7;
   localparam int ALERT_PULSE_CLKS = 6;

   // ******************************************************************
   // shared functions
   // ******************************************************************
   // serial form unrolled by the tool into the eight xor trees
   function automatic logic [CRC_W-1:0] checksum_over_word(input logic [WORD_W-1:0] d);
      logic [CRC_W-1:0] c;
      logic fb;
      c = CRC_INIT;
      fb = 1'b0;
      for (int i = WORD_W - 1; i >= 0; i--) begin
         fb = c[CRC_W-1] ^ d[i];
         c = {c[CRC_W-2:0], 1'b0} ^ ({CRC_W{fb}} & CRC_POLY);
      end
      // each bit reduces to its printed xor set; bit 6 likewise
      return c;
   endfunction : checksum_over_word

   // upper byte stands as ones unless masking or inversion uses it
   function automatic logic [WORD_W-1:0] form_word(input logic [DATA_W-1:0] data,
                                                   input logic [7:0] lane,
                                                   input logic use_upper);
      return {(use_upper ? lane : UPPER_ONES), data};
   endfunction : form_word

   // one transfer: {lane bit, eight data lanes}
   function automatic logic [LANES:0] beat_of(input logic [WORD_W-1:0] w,
                                              input logic [CRC_W-1:0] crc,
                                              input logic [3:0] idx);
      logic [LANES:0] b;
      b = {(LANES + 1){1'b1}};
      if (idx < CRC_BEAT) begin
         for (int n = 0; n < LANES; n++) begin
            b[n] = w[n * DATA_BEATS + int'(idx)];
         end
         b[LANES] = w[DATA_W + int'(idx)];
      end else if (idx == CRC_BEAT) begin
         b = {1'b1, crc};
      end
      return b;
   endfunction : beat_of

endpackage : wdcrc_pkg

// ===== verif/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import wdcrc_pkg::*;
   // *********************************************
   // bench
   // *********************************************
   logic clk, rstn, crc, wm, bi, mwm, mbi, vld, rdy, seen, wv, err, ab, wv2, err2, ab2;
   logic [63:0] dat, od;
   logic [7:0] lane, ol;
   logic [8:0] bt [10];
   int fails = 0, n_tests = 0, n, lo, sn, na;
   wdcrc_link_if lk ();
   wdcrc_link_if lk2 ();
   wdcrc_ctrl_end wdcrc_ctrl_end_i (.i_ref_clk(clk), .i_rstn(rstn), .i_crc_en(crc),
      .i_write_mask_function(wm), .i_bus_inversion_function(bi), .i_word_valid(vld),
      .i_data(dat), .i_mask_lane(lane), .o_ready(rdy), .o_alert_seen(seen), .link(lk));
   wdcrc_mem_end #(.ALERT_CLKS(6)) wdcrc_mem_end_i (.i_ref_clk(clk), .i_rstn(rstn),
      .i_crc_en(crc), .i_write_mask_function(mwm), .i_bus_inversion_function(mbi),
      .o_word_valid(wv), .o_data(od), .o_mask_lane(ol), .o_crc_err(err),
      .o_frame_abort(ab), .link(lk));
   // second memory end faces a hand driver that sends faults on purpose
   wdcrc_mem_end #(.ALERT_CLKS(6)) wdcrc_mem_end_i2 (.i_ref_clk(clk), .i_rstn(rstn),
      .i_crc_en(crc), .i_write_mask_function(mwm), .i_bus_inversion_function(mbi),
      .o_word_valid(wv2), .o_data(), .o_mask_lane(), .o_crc_err(err2),
      .o_frame_abort(ab2), .link(lk2));
   wdcrc_chk #(.ALERT_CLKS(6)) wdcrc_chk_i (.i_ref_clk(clk), .i_rstn(rstn),
      .beat_valid(lk.beat_valid), .dq(lk.dq), .mask_inversion_lane(lk.mask_inversion_lane),
      .alert_o(lk.alert_o), .alert_oe_n(lk.alert_oe_n), .alert_n(lk.alert_n));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // serial reference kept apart from the design's own function
   function automatic logic [7:0] ref_crc(input logic [71:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 71; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction : ref_crc
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("mismatches %0d of %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   // inputs move one ns after the edge, away from sampling
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   // m = {crc, wm, bi, mem wm, mem bi}; e = mismatch expected
   task automatic send(input logic [4:0] m, input logic e, input logic [63:0] d,
                       input logic [7:0] l);
      logic [71:0] wd;
      for (int k = 0; rdy !== 1'b1; k++) begin
         if (k > 30) begin
            fails++;
            print_verdict();
         end
         tick();
      end
      {crc, wm, bi, mwm, mbi} = m;
      dat = d;
      lane = l;
      vld = 1'b1;
      tick();
      vld = 1'b0;
      chk(rdy, 1'b0);
      n = 0;
      // every transfer is counted, so an overlong frame shows in n
      for (int i = 0; i < 20 && (n == 0 || lk.beat_valid); i++) begin
         if (lk.beat_valid === 1'b1 && n < 10) bt[n] = {lk.mask_inversion_lane, lk.dq};
         n += (lk.beat_valid === 1'b1);
         if (lk.beat_valid !== 1'b0 || n == 0) tick();
      end
      chk({rdy, lk.beat_valid}, 2'h2);
      wd = {(m[3] | m[2]) ? l : 8'hFF, d};
      chk(n, m[4] ? 10 : 8);
      for (int t = 0; t < 8; t++)
         for (int q = 0; q < 9; q++) chk(bt[t][q], wd[q*8+t]);
      if (m[4]) chk(bt[8], {1'b1, ref_crc(wd)});
      if (m[4]) chk(bt[9], 9'h1FF);
      chk({wv, err}, {1'b1, e});
      chk(od, d);
      chk(ol, (m[1] | m[0]) ? l : 8'hFF);
      lo = 0;
      sn = 0;
      na = 0;
      repeat (10) begin
         lo += (lk.alert_n === 1'b0);
         sn += (seen === 1'b1);
         na += (ab === 1'b1);
         tick();
      end
      chk(lo, e ? 6 : 0);
      chk(sn, lo);
      chk(na, 0);
   endtask : send
   // one frame of nb transfers on the second link, word flipped by fx
   task automatic raw(input logic [71:0] w, input logic [71:0] fx, input int nb,
                      input logic e);
      logic [71:0] x;
      logic [7:0] cs;
      logic [2:0] g;
      logic [7:0] b;
      x = w ^ fx;
      cs = ref_crc(w);
      g = 3'h0;
      for (int t = 0; t < nb; t++) begin
         for (int q = 0; q < 8; q++) b[q] = (t < 8) ? x[q*8+t] : (t == 8) ? cs[q] : 1'b1;
         lk2.beat_valid = 1'b1;
         lk2.dq = b;
         lk2.mask_inversion_lane = (t < 8) ? x[64+t] : 1'b1;
         tick();
      end
      lk2.beat_valid = 1'b0;
      lk2.dq = 8'hFF;
      lk2.mask_inversion_lane = 1'b1;
      lo = 0;
      repeat (10) begin
         g = g | {wv2, ab2, err2};
         lo += (lk2.alert_n === 1'b0);
         tick();
      end
      chk(g, (nb == 10) ? {2'b10, e} : 3'h2);
      chk(lo, e ? 6 : 0);
   endtask : raw
   task automatic t_modes();
      send(5'h10, 1'h0, 64'h0123456789ABCDEF, 8'h3C);
      send(5'h1A, 1'h0, 64'hFEDCBA9876543210, 8'h3C);
      send(5'h15, 1'h0, 64'h8000000000000001, 8'h80);
      send(5'h00, 1'h0, 64'hA5A5A5A5A5A5A5A5, 8'h00);
   endtask : t_modes
   // controller uses the upper byte, memory forces it to ones
   task automatic t_mismatch();
      send(5'h18, 1'h1, 64'h0, 8'h00);
   endtask : t_mismatch
   task automatic t_faults();
      {crc, mwm, mbi} = 3'h6;
      raw(72'h5A0123456789ABCDEF, 72'h0, 10, 1'b0);
      raw(72'h5A0123456789ABCDEF, 72'h1, 10, 1'b1);
      raw(72'h5A0123456789ABCDEF, 72'h81, 10, 1'b1);
      raw(72'h5A0123456789ABCDEF, 72'h7, 10, 1'b1);
      raw(72'h5A0123456789ABCDEF, 72'h0808080808080808, 10, 1'b1);
      raw(72'h5A0123456789ABCDEF, 72'h0, 4, 1'b0);
   endtask : t_faults
   // one-hot words against the printed xor sets, design function on all five, bench model on bits 0 and 71 only
   task automatic t_equations();
      chk(checksum_over_word(72'h1), 8'h07);
      chk(ref_crc(72'h1), 8'h07);
      chk(checksum_over_word(72'h1 << 71), 8'h34);
      chk(ref_crc(72'h1 << 71), 8'h34);
      chk(checksum_over_word(72'h1 << 70), 8'h1A);
      chk(checksum_over_word(72'h1 << 68), 8'h85);
      chk(checksum_over_word(72'h1 << 64), 8'h79);
   endtask : t_equations
   // reset cut into a running frame leaves both ends idle, then a frame passes
   task automatic t_reset();
      vld = 1'b1;
      tick();
      vld = 1'b0;
      tick();
      tick();
      rstn = 1'b0;
      tick();
      chk({rdy, lk.beat_valid, lk.dq, lk.mask_inversion_lane, lk.alert_n}, 12'hBFF);
      chk({wv, err, ab}, 3'h0);
      chk(od, 64'h0);
      tick();
      rstn = 1'b1;
      send(5'h10, 1'h0, 64'h0F1E2D3C4B5A6978, 8'h00);
   endtask : t_reset
   initial begin
      {rstn, crc, wm, bi, mwm, mbi, vld} = 7'h00;
      dat = 64'h0;
      lane = 8'h00;
      lk2.beat_valid = 1'b0;
      lk2.dq = 8'hFF;
      lk2.mask_inversion_lane = 1'b1;
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      chk(ol, 8'hFF);
      t_equations();
      t_modes();
      t_mismatch();
      t_reset();
      t_faults();
      print_verdict();
   end
endmodule : testbench

// ===== verif/wdcrc_chk.sv
module wdcrc_chk #(
   parameter int ALERT_CLKS = 6
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic beat_valid,
   input wire logic [7:0] dq,
   input wire logic mask_inversion_lane,
   input wire logic alert_o,
   input wire logic alert_oe_n,
   input wire logic alert_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // *********************************************
   // link watch
   // *********************************************
   logic [7:0] lo_q;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   // run length of the alert pulse, saturating so it never wraps
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) lo_q <= 8'h00;
      else if (!alert_n) lo_q <= (lo_q == 8'hFF) ? lo_q : lo_q + 8'h01;
      else lo_q <= 8'h00;
   end
   sequence s_start;
      $rose(beat_valid);
   endsequence
   sequence s_ten;
      s_start ##9 beat_valid;
   endsequence
   a_frame_min: assert property (s_start |-> beat_valid [*8])
      else $error("frame shorter than eight");
   a_frame_max: assert property (s_ten |=> !beat_valid)
      else $error("frame longer than ten");
   a_fill_ones: assert property (s_ten |-> dq == 8'hFF && mask_inversion_lane)
      else $error("last transfer not ones");
   a_lane_crc: assert property (s_start ##8 beat_valid |-> mask_inversion_lane)
      else $error("lane not one with checksum");
   a_idle_dq: assert property (!beat_valid |-> dq == 8'hFF && mask_inversion_lane)
      else $error("idle link not high");
   a_alert_width: assert property ($rose(alert_n) |-> lo_q >= ALERT_CLKS)
      else $error("alert pulse too short");
   a_alert_drive: assert property (!alert_oe_n |-> !alert_o)
      else $error("alert driven high");
   a_alert_cause: assert property ($fell(alert_n) |-> $past(beat_valid))
      else $error("alert without frame end");
   // errors come back as a pulse, never as a level that stays
   a_alert_release: assert property ($fell(alert_n) |-> ##[1:255] alert_n)
      else $error("alert never released");
endmodule : wdcrc_chk
